/* verilog/rtsw_host.sv */
// host controller: power-up quiet time, battery check, user access, clock snapshot
`timescale 1ns/1ps
`default_nettype none
module rtsw_host #(
  parameter int P_QUIET_CYC = rtsw_pkg::QUIET_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_pwr_ok,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [10:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_time_req,
  input wire logic [7:0] i_byte_in,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [55:0] o_time,
  output logic o_time_valid,
  output logic o_batt_low,
  output logic o_cs_n,
  output logic o_store_strobe_n,
  output logic o_out_drive_n,
  output logic [10:0] o_addr_lines,
  output logic [7:0] o_byte_out,
  output logic o_byte_oe
);
  localparam int QW = $clog2(P_QUIET_CYC + 1);
  typedef enum logic [3:0] {
    ST_WAIT = 4'h0, ST_BC_RD = 4'h1, ST_BC_WR = 4'h3, ST_BC_VF = 4'h2,
    ST_BC_RS = 4'h6, ST_IDLE = 4'h7, ST_USER = 4'h5, ST_T_CRD = 4'h4,
    ST_T_HOLD = 4'hc, ST_T_RD = 4'hd, ST_T_REL = 4'hf
  } rtsw_st_t;
  rtsw_st_t state_reg;
  logic pwr_s1_reg, pwr_s2_reg, busy_reg, hold_set_reg;
  logic ready_reg, done_reg, tvalid_reg, batt_low_reg, usr_wr_reg;
  logic [QW-1:0] quiet_reg;
  logic [7:0] save_reg, ctrl_reg, usr_wdata_reg, rdata_reg;
  logic [10:0] usr_addr_reg;
  logic [2:0] idx_reg;
  logic [7:1][7:0] time_reg;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  // access description for the current step
  wire quiet_done = (quiet_reg == QW'(P_QUIET_CYC));
  wire inhibit = !pwr_s2_reg; // R8 R13
  wire is_ctrl = (state_reg == ST_T_CRD) || (state_reg == ST_T_HOLD) ||
                 (state_reg == ST_T_REL);
  wire is_bchk = (state_reg == ST_BC_RD) || (state_reg == ST_BC_WR) ||
                 (state_reg == ST_BC_VF) || (state_reg == ST_BC_RS);
  wire acc_st = is_ctrl || is_bchk || (state_reg == ST_USER) || (state_reg == ST_T_RD);
  wire acc_wr = (state_reg == ST_BC_WR) || (state_reg == ST_BC_RS) ||
                (state_reg == ST_T_HOLD) || (state_reg == ST_T_REL) ||
                ((state_reg == ST_USER) && usr_wr_reg);
  wire [10:0] acc_addr = is_bchk ? rtsw_pkg::BCHK_ADDR :
                         is_ctrl ? rtsw_pkg::CTRL_ADDR :
                         (state_reg == ST_T_RD) ? rtsw_pkg::CTRL_ADDR + {8'h00, idx_reg} :
                         usr_addr_reg; // R19 R20
  wire [7:0] acc_wdata = (state_reg == ST_BC_WR) ? ~save_reg :
                         (state_reg == ST_BC_RS) ? save_reg :
                         (state_reg == ST_T_HOLD) ? (ctrl_reg | rtsw_pkg::HOLD_MASK) :
                         (state_reg == ST_T_REL) ? (ctrl_reg & ~rtsw_pkg::HOLD_MASK) :
                         usr_wdata_reg;
  wire acc_start = acc_st && !busy_reg && !inhibit;

  rtsw_cycle #(
    .AW(rtsw_pkg::ADDR_W),
    .DW(rtsw_pkg::DATA_W)
  ) u_cycle (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(acc_start),
    .i_wr(acc_wr),
    .i_addr(acc_addr),
    .i_wdata(acc_wdata),
    .i_inhibit(inhibit),
    .i_byte_in(i_byte_in),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_cs_n(o_cs_n),
    .o_we_n(o_store_strobe_n),
    .o_oe_n(o_out_drive_n),
    .o_addr(o_addr_lines),
    .o_byte_out(o_byte_out),
    .o_byte_oe(o_byte_oe)
  );

  // power-good pin crosses in; quiet time counts after it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_s1_reg <= 1'b0;
      pwr_s2_reg <= 1'b0;
      quiet_reg <= '0;
    end else begin
      pwr_s1_reg <= i_pwr_ok;
      pwr_s2_reg <= pwr_s1_reg;
      if (inhibit) quiet_reg <= '0; // R13
      else if (!quiet_done) quiet_reg <= quiet_reg + QW'(1);
    end
  end
  // step sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_WAIT;
      busy_reg <= 1'b0;
      hold_set_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      tvalid_reg <= 1'b0;
      batt_low_reg <= 1'b0;
      usr_wr_reg <= 1'b0;
      save_reg <= rtsw_pkg::BYTE_RST;
      ctrl_reg <= rtsw_pkg::BYTE_RST;
      usr_wdata_reg <= rtsw_pkg::BYTE_RST;
      rdata_reg <= rtsw_pkg::BYTE_RST;
      usr_addr_reg <= '0;
      idx_reg <= 3'h1;
      time_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      tvalid_reg <= 1'b0;
      if (acc_start) busy_reg <= 1'b1;
      else if (cyc_done) busy_reg <= 1'b0;
      if (inhibit) begin
        state_reg <= ST_WAIT; // R8 R9
        busy_reg <= 1'b0;
        hold_set_reg <= 1'b0;
        ready_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_WAIT: if (quiet_done) state_reg <= ST_BC_RD; // R13 R10
          ST_BC_RD: if (cyc_done) begin
            save_reg <= cyc_rdata;
            state_reg <= ST_BC_WR;
          end
          ST_BC_WR: if (cyc_done) state_reg <= ST_BC_VF; // R11
          ST_BC_VF: if (cyc_done) begin
            batt_low_reg <= (cyc_rdata != ~save_reg); // R11 R12
            state_reg <= ST_BC_RS;
          end
          ST_BC_RS: if (cyc_done) begin
            ready_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          ST_IDLE: if (i_time_req) begin
            ready_reg <= 1'b0;
            state_reg <= ST_T_CRD;
          end else if (i_req) begin
            ready_reg <= 1'b0;
            usr_wr_reg <= i_wr;
            usr_addr_reg <= i_addr;
            usr_wdata_reg <= i_wdata;
            state_reg <= ST_USER;
          end
          ST_USER: if (cyc_done) begin
            if (!usr_wr_reg) rdata_reg <= cyc_rdata; // a write keeps the last read byte
            done_reg <= 1'b1;
            ready_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          ST_T_CRD: if (cyc_done) begin
            ctrl_reg <= cyc_rdata;
            state_reg <= ST_T_HOLD;
          end
          ST_T_HOLD: if (cyc_done) begin
            hold_set_reg <= |(o_byte_out & rtsw_pkg::HOLD_MASK) &&
                            (o_addr_lines == rtsw_pkg::CTRL_ADDR); // R14 R15
            idx_reg <= 3'h1;
            state_reg <= ST_T_RD;
          end
          ST_T_RD: if (cyc_done) begin
            time_reg[idx_reg] <= cyc_rdata; // R16
            if (idx_reg == rtsw_pkg::CLK_BYTES) state_reg <= ST_T_REL;
            else idx_reg <= idx_reg + 3'h1;
          end
          ST_T_REL: if (cyc_done) begin
            hold_set_reg <= 1'b0; // R18
            tvalid_reg <= 1'b1;
            ready_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_WAIT;
        endcase
      end
    end
  end
  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_rdata = rdata_reg;
  assign o_time = time_reg;
  assign o_time_valid = tvalid_reg;
  assign o_batt_low = batt_low_reg;

  // power-up and snapshot checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_quiet_cs;
    !pwr_s2_reg |=> o_cs_n;
  endproperty
  a_quiet_cs: assert property (p_quiet_cs) else $error("select during power loss"); // R13
  property p_quiet_time;
    $fell(o_cs_n) |-> $past(quiet_done);
  endproperty
  a_quiet_time: assert property (p_quiet_time) else $error("select before quiet time"); // R13
  property p_hold_first;
    (state_reg == ST_T_RD) && !o_out_drive_n |-> hold_set_reg && ctrl_reg[6] == 1'b0;
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("clock read without hold"); // R14
endmodule // rtsw_host
`default_nettype wire

/* verilog/rtsw_pkg.sv */
// constants shared by the clock-sram host controller and its bus-cycle engine
// Function
// [R1] write cycle while select and strobe low
// [R2] write starts at later falling edge
// [R3] write ends at first rising edge
// [R4] host holds address through write cycle
// [R5] host holds data around strobe rise
// [R6] host keeps output drive high writing
// [R7] strobe fall floats device data outputs
// [R8] power fail deselects and blocks writes
// [R9] power fail corrupts only addressed byte
// [R10] battery checked while supply rises
// [R11] low battery drops first write
// [R12] low battery flag clears after it
// [R13] host keeps select high at power-up
// [R14] host halts clock updates before reading
// [R15] hold bit stops clock byte updates
// [R16] held bytes keep halt-time date, time
// [R17] halt waits for update in progress
// [R18] clearing hold resumes within one second
// [R19] top eight bytes are clock bytes
// [R20] lowest clock byte is control byte
// [R21] select low, strobe high reads
// [R22] power and battery status are inputs
`default_nettype none
package rtsw_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 40;
  // bus timings in ns, recovery time in ms, sync depth in cycles, slowest speed grade
  localparam int T_WP_NS = 120;
  localparam int T_ACC_NS = 200;
  localparam int T_HOLD_NS = 10;
  localparam int T_REC_MS = 2;
  localparam int SYNC_CYC = 2;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int HOLD_CYC = ((T_HOLD_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                            (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int QUIET_CYC = T_REC_MS * 1000000 / CLK_NS;
  // memory map
  localparam logic [10:0] CTRL_ADDR = 11'h7f8;
  localparam logic [10:0] BCHK_ADDR = 11'h000;
  localparam logic [7:0] HOLD_MASK = 8'h40;
  localparam logic [2:0] CLK_BYTES = 3'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage
`default_nettype wire

/* verilog/rtsw_cycle.sv */
// one asynchronous sram bus cycle: setup, strobe, hold
`timescale 1ns/1ps
`default_nettype none
module rtsw_cycle #(
  parameter int AW = rtsw_pkg::ADDR_W,
  parameter int DW = rtsw_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_inhibit,
  input wire logic [DW-1:0] i_byte_in,
  output logic o_done,
  output logic [DW-1:0] o_rdata,
  output logic o_cs_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_byte_out,
  output logic o_byte_oe
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_SETUP = 2'b01, C_STRB = 2'b11, C_HOLD = 2'b10
  } rtsw_cyc_t;
  rtsw_cyc_t state_reg, state_next;
  logic [3:0] cnt_reg;
  logic wr_reg, done_reg, cs_n_reg, we_n_reg, oe_n_reg, byte_oe_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] dout_reg, rdata_reg, byte_s1_reg, byte_s2_reg;
  // decode of the pending access
  wire wr_eff = (state_reg == C_IDLE) ? i_wr : wr_reg;
  wire [3:0] strb_len = wr_reg ? 4'(rtsw_pkg::WP_CYC) : 4'(rtsw_pkg::ACC_CYC);
  wire last_cnt = (cnt_reg == 4'h1);
  wire next_sel = (state_next == C_SETUP) || (state_next == C_STRB);
  // cycle sequencing; power loss aborts at once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      C_IDLE: if (i_start) state_next = C_SETUP;
      C_SETUP: state_next = C_STRB;
      C_STRB: if (last_cnt) state_next = C_HOLD;
      C_HOLD: if (last_cnt) state_next = C_IDLE;
      default: state_next = C_IDLE;
    endcase
    if (i_inhibit) state_next = C_IDLE; // R8
  end
  // state, counter and latched request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= C_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      dout_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == C_SETUP) cnt_reg <= strb_len;
      else if (state_reg == C_STRB && last_cnt) cnt_reg <= 4'(rtsw_pkg::HOLD_CYC);
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
      if (state_reg == C_IDLE && i_start) begin
        wr_reg <= i_wr;
        addr_reg <= i_addr; // R4
        dout_reg <= i_wdata;
      end
    end
  end
  // pin drivers registered from the next state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      byte_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      cs_n_reg <= !next_sel; // R2 R3
      we_n_reg <= !(state_next == C_STRB && wr_reg); // R1
      oe_n_reg <= !(state_next == C_STRB && !wr_reg); // R6 R21
      byte_oe_reg <= (state_next != C_IDLE) && wr_eff; // R5
      done_reg <= (state_reg == C_HOLD) && (state_next == C_IDLE) && !i_inhibit;
      if (state_reg == C_STRB && last_cnt && !wr_reg) rdata_reg <= byte_s2_reg;
    end
  end
  // data pins cross in through two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      byte_s1_reg <= '0;
      byte_s2_reg <= '0;
    end else begin
      byte_s1_reg <= i_byte_in;
      byte_s2_reg <= byte_s1_reg;
    end
  end
  assign o_done = done_reg;
  assign o_rdata = rdata_reg;
  assign o_cs_n = cs_n_reg;
  assign o_we_n = we_n_reg;
  assign o_oe_n = oe_n_reg;
  assign o_addr = addr_reg;
  assign o_byte_out = dout_reg;
  assign o_byte_oe = byte_oe_reg;

  // checks on the produced bus cycle
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst || i_inhibit);
  sequence s_strobe_low;
    (!o_we_n && !o_cs_n) [*3];
  endsequence
  sequence s_strobe_end;
    o_we_n && o_cs_n;
  endsequence
  property p_we_width;
    $fell(o_we_n) |-> s_strobe_low ##1 s_strobe_end;
  endproperty
  a_we_width: assert property (p_we_width) else $error("strobe width wrong"); // R1
  property p_addr_stable;
    (!o_cs_n && $past(!o_cs_n)) || $rose(o_cs_n) |-> $stable(o_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved"); // R4
  property p_data_hold;
    $rose(o_we_n) |-> o_byte_oe && $stable(o_byte_out) && $past(o_byte_oe, 4);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data window"); // R5
  property p_oe_write;
    o_byte_oe |-> o_oe_n;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("output drive during write"); // R6
  property p_read_len;
    $fell(o_oe_n) |-> (!o_oe_n && o_we_n)[*7] ##1 o_oe_n;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe length"); // R21
endmodule // rtsw_cycle
`default_nettype wire

/* tb/rtsw_dev_model.sv */
// behavioural clock sram seen at its pins, with battery flag and clock bytes
`timescale 1ns/1ps
`default_nettype none
module rtsw_dev_model #(
  parameter int P_TICK_NS = 8000
) (
  input wire logic i_pwr_ok,
  input wire logic i_batt_bad,
  input wire logic i_cs_n,
  input wire logic i_store_strobe_n,
  input wire logic i_out_drive_n,
  input wire logic [10:0] i_addr_lines,
  input wire logic [7:0] i_host_byte,
  input wire logic i_host_oe,
  output logic [7:0] o_io_byte,
  output logic [55:0] o_held,
  output logic o_batt_low
);
  logic [7:0] mem [0:2047];
  logic [55:0] count_reg;
  logic [7:0] last_reg;
  logic wr_act;
  logic wr_open;
  logic rd_drv;
  // write and read modes, both gated by supply good
  assign wr_act = i_pwr_ok & ~i_cs_n & ~i_store_strobe_n;
  assign rd_drv = i_pwr_ok & ~i_cs_n & i_store_strobe_n & ~i_out_drive_n;
  initial begin
    for (int k = 0; k < 2048; k++) mem[k] = 8'h00;
    count_reg = 56'h0;
    last_reg = 8'h00;
    wr_open = 1'b0;
    o_batt_low = 1'b0;
    o_held = 56'h0;
  end
  // battery sampled as supply comes up
  always @(posedge i_pwr_ok) o_batt_low = i_batt_bad;
  // a write opens once select and strobe are both low
  always @(posedge wr_act) wr_open = 1'b1;
  // commit at the first rising select or strobe edge
  always @(negedge wr_act) begin
    if (wr_open !== 1'b1) wr_open = 1'b0; // start-up edge, no write open
    else if (!i_pwr_ok) begin
      mem[i_addr_lines] = ~mem[i_addr_lines];
    end else if (o_batt_low) begin
      o_batt_low = 1'b0;
    end else begin
      if (i_addr_lines == 11'h7f8 && o_io_byte[6] && !mem[11'h7f8][6]) begin
        for (int k = 1; k < 8; k++) o_held[8*k-1 -: 8] = mem[11'h7f8 + k];
      end
      mem[i_addr_lines] = o_io_byte;
    end
    wr_open = 1'b0;
  end
  // counters always run; bytes refresh together unless held
  always begin
    #(P_TICK_NS);
    count_reg = count_reg + 56'h01010101010101;
    if (!mem[11'h7f8][6]) begin
      for (int k = 1; k < 8; k++) mem[11'h7f8 + k] = count_reg[8*k-1 -: 8];
    end
  end
  // pin level: host, device, or floating inverse of last driven value
  always @* begin
    if (i_host_oe) o_io_byte = i_host_byte;
    else if (rd_drv) o_io_byte = mem[i_addr_lines];
    else o_io_byte = ~last_reg;
  end
  always @(o_io_byte) if (i_host_oe || rd_drv) last_reg = o_io_byte;
endmodule // rtsw_dev_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench: host controller against the behavioural clock sram
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk, i_nrst, i_pwr_ok, i_req, i_wr, i_time_req, batt_bad, dev_low;
  logic o_ready, o_done, o_time_valid, o_batt_low, o_cs_n, o_store_strobe_n;
  logic o_out_drive_n, o_byte_oe;
  logic [10:0] i_addr, o_addr_lines;
  logic [7:0] i_wdata, io_byte, o_rdata, o_byte_out, last_exp;
  logic [55:0] o_time, held;
  logic [7:0] shadow [0:2047];
  logic [7:0] exp_q [$];
  logic [10:0] a_list [0:3];
  logic [31:0] seed, r;
  int err_count, total_checks;
  rtsw_host #(.P_QUIET_CYC(20)) rtsw_host_i (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_pwr_ok(i_pwr_ok), .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_time_req(i_time_req), .i_byte_in(io_byte), .o_ready(o_ready), .o_done(o_done),
    .o_rdata(o_rdata), .o_time(o_time), .o_time_valid(o_time_valid),
    .o_batt_low(o_batt_low), .o_cs_n(o_cs_n), .o_store_strobe_n(o_store_strobe_n),
    .o_out_drive_n(o_out_drive_n), .o_addr_lines(o_addr_lines),
    .o_byte_out(o_byte_out), .o_byte_oe(o_byte_oe));
  rtsw_dev_model rtsw_dev_model_i (.i_pwr_ok(i_pwr_ok), .i_batt_bad(batt_bad),
    .i_cs_n(o_cs_n), .i_store_strobe_n(o_store_strobe_n), .i_out_drive_n(o_out_drive_n),
    .i_addr_lines(o_addr_lines), .i_host_byte(o_byte_out), .i_host_oe(o_byte_oe),
    .o_io_byte(io_byte), .o_held(held), .o_batt_low(dev_low));
  // clock, 40 ns period
  always #20 i_clk = ~i_clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    check(o_ready, 1'b1);
  endtask
  // one user access; expected read byte noted in the queue
  task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d);
    wait_ready();
    i_req = 1'b1;
    i_wr = wr;
    i_addr = a;
    i_wdata = d;
    if (wr) shadow[a] = d;
    else last_exp = shadow[a];
    exp_q.push_back(last_exp);
    @(negedge i_clk);
    i_req = 1'b0;
  endtask
  // result watcher and write-cycle pin watcher
  always @(posedge i_clk) begin
    #1;
    if (o_done === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check(o_rdata, exp_q.pop_front());
    end
    if (o_cs_n === 1'b0 && o_store_strobe_n === 1'b0) check(o_out_drive_n, 1'b1);
  end
  // watchdog
  initial begin
    #1200000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    i_pwr_ok = 1'b0;
    i_req = 1'b0;
    i_wr = 1'b0;
    i_time_req = 1'b0;
    i_addr = 11'h000;
    i_wdata = 8'h00;
    batt_bad = 1'b1;
    last_exp = 8'h00;
    seed = 32'ha73f1301;
    for (int k = 0; k < 2048; k++) shadow[k] = 8'h00;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_pwr_ok = 1'b1;
    wait_ready();
    check(o_batt_low, 1'b1);
    check(dev_low, 1'b0);
    check(rtsw_dev_model_i.mem[0], 8'h00);
    $display("test battery done");
    // back-to-back random writes, then read-backs
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      a_list[k] = {1'b0, 2'(k), r[7:0]}; // distinct addresses
      access(1'b1, a_list[k], r[17:10]);
    end
    for (int k = 0; k < 4; k++) access(1'b0, a_list[k], 8'h00);
    wait_ready();
    check(exp_q.size(), 0);
    $display("test write read done");
    // clock snapshot holds the bytes, then refresh resumes
    i_time_req = 1'b1;
    @(negedge i_clk);
    i_time_req = 1'b0;
    for (int n = 0; n < 400 && o_time_valid !== 1'b1; n++) @(posedge i_clk) #1;
    check(o_time_valid, 1'b1);
    check(o_time, held);
    check(rtsw_dev_model_i.mem[11'h7f8][6], 1'b0);
    @(negedge i_clk);
    repeat (250) @(negedge i_clk);
    check(rtsw_dev_model_i.mem[11'h7f9] !== held[7:0], 1'b1);
    $display("test snapshot done");
    // supply lost early in a write
    wait_ready();
    i_req = 1'b1;
    i_wr = 1'b1;
    i_addr = a_list[0];
    i_wdata = ~shadow[a_list[0]];
    @(negedge i_clk);
    i_req = 1'b0;
    repeat (2) @(negedge i_clk);
    batt_bad = 1'b0;
    i_pwr_ok = 1'b0;
    repeat (4) @(negedge i_clk);
    check({o_cs_n, o_store_strobe_n, o_ready}, 3'b110);
    for (int k = 1; k < 4; k++) check(rtsw_dev_model_i.mem[a_list[k]], shadow[a_list[k]]);
    shadow[a_list[0]] = rtsw_dev_model_i.mem[a_list[0]];
    i_pwr_ok = 1'b1;
    wait_ready();
    check(o_batt_low, 1'b0);
    access(1'b0, a_list[1], 8'h00);
    wait_ready();
    check(exp_q.size(), 0);
    $display("test power fail done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
